/* skip_core_pkg.sv */
package skip_core_pkg;

    // bus register map, byte addresses
    localparam logic [11:0] OFF_INSTR = 12'h000;
    localparam logic [11:0] OFF_ACC = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_PC = 12'h00C;
    localparam logic [11:0] OFF_PC_LATCH = 12'h010;
    localparam logic [11:0] OFF_CYCLES = 12'h014;
    localparam logic [11:0] OFF_FILE_BASE = 12'h100;
    localparam logic [11:0] OFF_FILE_LAST = 12'h2FC;

    // status register fields
    localparam int STAT_ZERO_POS = 0;
    localparam int STAT_BUSY_POS = 1;

    // instruction word fields
    localparam int OPCODE_LSB = 12;
    localparam int OPCODE_W = 4;
    localparam int DEST_POS = 7;
    localparam int FILE_ADDR_W = 7;
    localparam int LIT8_W = 8;
    localparam int JUMP_LIT_W = 11;
    localparam int PC_W = 15;
    localparam int PC_LATCH_W = 7;
    localparam int PC_LATCH_LO = 3;
    localparam int PC_LATCH_HI = 6;
    localparam int DATA_W = 8;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [6:0] PC_LATCH_RST = 7'h00;
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [31:0] CYCLES_RST = 32'h0000_0000;
    localparam logic ZERO_RST = 1'b0;

    // program counter steps
    localparam logic [14:0] PC_STEP = 15'h0001;
    localparam logic [14:0] PC_SKIP_STEP = 15'h0002;

    // operation codes carried in the opcode field
    typedef enum logic [3:0] {
        OP_NOP,
        OP_DECREMENT_SKIP_ON_ZERO,
        OP_INCREMENT_SKIP_ON_ZERO,
        OP_INCREMENT_FILE,
        OP_UNCONDITIONAL_JUMP,
        OP_OR_LITERAL_INTO_ACCUMULATOR,
        OP_OR_ACCUMULATOR_WITH_FILE
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_SECOND
    } exec_state_t;

    // 8-bit zero test
    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == 8'h00);
    endfunction

    // file register index from a byte address in the file window
    function automatic logic [6:0] file_index(input logic [11:0] addr);
        logic [11:0] offset;
        offset = addr - OFF_FILE_BASE;
        file_index = offset[8:2];
    endfunction

endpackage

/* skip_core_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module skip_core_alu
    import skip_core_pkg::*;
(
    input wire logic [3:0] opcode_i,
    input wire logic dest_i,
    input wire logic [7:0] literal_i,
    input wire logic [7:0] file_val_i,
    input wire logic [7:0] acc_i,
    output logic [7:0] result_o,
    output logic write_acc_o,
    output logic write_file_o,
    output logic update_zero_o,
    output logic skip_o,
    output logic jump_o
);

    op_t op;

    assign op = op_t'(opcode_i);

    // result and destination selection per operation
    always_comb begin
        result_o = 8'h00;
        write_acc_o = 1'b0;
        write_file_o = 1'b0;
        update_zero_o = 1'b0;
        skip_o = 1'b0;
        jump_o = 1'b0;
        unique case (op)
            OP_DECREMENT_SKIP_ON_ZERO: begin
                result_o = file_val_i - 8'h01;
                write_acc_o = !dest_i;
                write_file_o = dest_i;
                skip_o = is_zero(result_o);
            end
            OP_INCREMENT_SKIP_ON_ZERO: begin
                result_o = file_val_i + 8'h01;
                write_acc_o = !dest_i;
                write_file_o = dest_i;
                skip_o = is_zero(result_o);
            end
            OP_INCREMENT_FILE: begin
                result_o = file_val_i + 8'h01;
                write_acc_o = !dest_i;
                write_file_o = dest_i;
                update_zero_o = 1'b1;
            end
            OP_UNCONDITIONAL_JUMP: begin
                jump_o = 1'b1;
            end
            OP_OR_LITERAL_INTO_ACCUMULATOR: begin
                result_o = acc_i | literal_i;
                write_acc_o = 1'b1;
                update_zero_o = 1'b1;
            end
            OP_OR_ACCUMULATOR_WITH_FILE: begin
                result_o = acc_i | file_val_i;
                write_acc_o = !dest_i;
                write_file_o = dest_i;
                update_zero_o = 1'b1;
            end
            default: begin
                result_o = 8'h00; // unknown codes act as no-operation
            end
        endcase
    end

endmodule
`default_nettype wire

/* skip_core_file_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module skip_core_file_ram #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_a_addr_i,
    output logic [WIDTH-1:0] rd_a_data_o,
    input wire logic [$clog2(DEPTH)-1:0] rd_b_addr_i,
    output logic [WIDTH-1:0] rd_b_data_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    // two asynchronous read ports
    assign rd_a_data_o = mem[rd_a_addr_i];
    assign rd_b_data_o = mem[rd_b_addr_i];

    // single write port, cleared at reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

endmodule
`default_nettype wire

/* skip_core.sv */
// Overview of operation
// - decrement-skip-on-zero subtracts one from file f and writes accumulator (d=0) or f (d=1), flags untouched.
// - a zero decrement result discards the next instruction for a no-operation, taking two cycles.
// - increment-skip-on-zero adds one to file f, writes per d, flags untouched, skipping on a zero result.
// - the jump loads its 11-bit literal into pc 10:0 and latch bits 6:3 into pc 14:11.
// - the jump takes two instruction cycles and leaves every flag alone.
// - or-literal ORs the accumulator with an 8-bit literal into the accumulator and updates zero.
// - increment-file adds one to file f, writes per d and updates zero.
// - or-accumulator-with-file ORs the accumulator with file f, writes per d and updates zero.
`timescale 1ns/1ps
`default_nettype none
module skip_core
    import skip_core_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o
);

    // bus data phase bookkeeping
    logic dphase_reg;
    logic dphase_next;
    logic dwrite_reg;
    logic [11:0] daddr_reg;
    logic rd_loaded_reg;
    logic [31:0] hrdata_reg;

    // core architectural state
    exec_state_t state_reg;
    exec_state_t state_next;
    logic [15:0] instr_reg;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic zero_reg;
    logic zero_next;
    logic [14:0] pc_reg;
    logic [14:0] pc_next;
    logic [6:0] pc_latch_reg;
    logic [31:0] cycles_reg;

    // bus decode wires
    wire addr_accept;
    wire busy;
    wire bus_done;
    wire bus_wr_done;
    wire hit_instr;
    wire hit_acc;
    wire hit_status;
    wire hit_pc;
    wire hit_pc_latch;
    wire hit_cycles;
    wire hit_file;
    wire [6:0] bus_file_idx;
    wire [7:0] bus_file_val;
    wire [31:0] read_mux;

    // register contents widened to a bus word, upper bits zero
    wire [31:0] word_instr;
    wire [31:0] word_acc;
    wire [31:0] word_status;
    wire [31:0] word_pc;
    wire [31:0] word_latch;
    wire [31:0] word_file;

    // execution wires
    wire exec_now;
    wire [3:0] instr_opcode;
    wire instr_dest;
    wire [7:0] instr_literal;
    wire [6:0] instr_file_idx;
    wire [7:0] instr_file_val;
    wire [7:0] alu_result;
    wire alu_write_acc;
    wire alu_write_file;
    wire alu_update_zero;
    wire alu_skip;
    wire alu_jump;
    wire [14:0] jump_target;
    wire ram_wr_en;
    wire [6:0] ram_wr_addr;
    wire [7:0] ram_wr_data;

    // address phase accepted on a selected nonsequential or sequential transfer
    assign addr_accept = hsel_i && hready_i && htrans_i[1];
    assign busy = (state_reg != ST_IDLE);

    // writes finish once idle; reads need their data register loaded first
    assign bus_done = dphase_reg && !busy && (dwrite_reg || rd_loaded_reg);
    assign bus_wr_done = bus_done && dwrite_reg;
    assign hreadyout_o = !dphase_reg || bus_done;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_reg;

    // register decode on the latched data phase address
    assign hit_instr = (daddr_reg == OFF_INSTR);
    assign hit_acc = (daddr_reg == OFF_ACC);
    assign hit_status = (daddr_reg == OFF_STATUS);
    assign hit_pc = (daddr_reg == OFF_PC);
    assign hit_pc_latch = (daddr_reg == OFF_PC_LATCH);
    assign hit_cycles = (daddr_reg == OFF_CYCLES);
    assign hit_file = (daddr_reg >= OFF_FILE_BASE) && (daddr_reg <= OFF_FILE_LAST)
        && (daddr_reg[1:0] == 2'b00);
    assign bus_file_idx = file_index(daddr_reg);

    // register words padded to the bus width
    assign word_instr = {16'h0000, instr_reg};
    assign word_acc = {24'h000000, acc_reg};
    assign word_status = {30'h0, busy, zero_reg};
    assign word_pc = {17'h0, pc_reg};
    assign word_latch = {25'h0, pc_latch_reg};
    assign word_file = {24'h000000, bus_file_val};

    // read data selection, unmapped addresses read as zero
    assign read_mux = hit_instr ? word_instr :
        hit_acc ? word_acc :
        hit_status ? word_status :
        hit_pc ? word_pc :
        hit_pc_latch ? word_latch :
        hit_cycles ? cycles_reg :
        hit_file ? word_file : 32'h0000_0000;

    // next data phase flag
    assign dphase_next = addr_accept ? 1'b1 : (bus_done ? 1'b0 : dphase_reg);

    // bus side flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            daddr_reg <= 12'h000;
        end else begin
            dphase_reg <= dphase_next;
            if (addr_accept) begin
                dwrite_reg <= hwrite_i;
                daddr_reg <= haddr_i[11:0];
            end
        end
    end

    // read data captured once the core is idle, one wait state per read plus any busy cycles
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_loaded_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end else if (dphase_reg && !dwrite_reg && !busy && !rd_loaded_reg) begin
            rd_loaded_reg <= 1'b1;
            hrdata_reg <= read_mux;
        end else if (bus_done) begin
            rd_loaded_reg <= 1'b0;
        end
    end

    // execution operand fields
    assign exec_now = (state_reg == ST_EXEC);
    assign instr_opcode = instr_reg[OPCODE_LSB +: OPCODE_W];
    assign instr_dest = instr_reg[DEST_POS];
    assign instr_literal = instr_reg[LIT8_W-1:0];
    assign instr_file_idx = instr_reg[FILE_ADDR_W-1:0];
    assign jump_target = {pc_latch_reg[PC_LATCH_HI:PC_LATCH_LO],
        instr_reg[JUMP_LIT_W-1:0]};

    skip_core_alu u_alu (
        .opcode_i(instr_opcode),
        .dest_i(instr_dest),
        .literal_i(instr_literal),
        .file_val_i(instr_file_val),
        .acc_i(acc_reg),
        .result_o(alu_result),
        .write_acc_o(alu_write_acc),
        .write_file_o(alu_write_file),
        .update_zero_o(alu_update_zero),
        .skip_o(alu_skip),
        .jump_o(alu_jump)
    );

    // file write port: execution has it in the execute state, otherwise the bus
    assign ram_wr_en = (exec_now && alu_write_file) || (bus_wr_done && hit_file);
    assign ram_wr_addr = exec_now ? instr_file_idx : bus_file_idx;
    assign ram_wr_data = exec_now ? alu_result : hwdata_i[7:0];

    skip_core_file_ram #(
        .DEPTH(FILE_DEPTH),
        .WIDTH(DATA_W)
    ) u_file (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_en_i(ram_wr_en),
        .wr_addr_i(ram_wr_addr),
        .wr_data_i(ram_wr_data),
        .rd_a_addr_i(instr_file_idx),
        .rd_a_data_o(instr_file_val),
        .rd_b_addr_i(bus_file_idx),
        .rd_b_data_o(bus_file_val)
    );

    // sequencing: skip and jump add a second cycle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (bus_wr_done && hit_instr) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (alu_skip || alu_jump) begin
                    state_next = ST_SECOND;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_SECOND: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // accumulator next value
    always_comb begin
        acc_next = acc_reg;
        if (exec_now && alu_write_acc) begin
            acc_next = alu_result;
        end else if (bus_wr_done && hit_acc) begin
            acc_next = hwdata_i[7:0];
        end
    end

    // zero flag moves for the flag-updating operations and for bus writes to the status register
    always_comb begin
        zero_next = zero_reg;
        if (exec_now && alu_update_zero) begin
            zero_next = is_zero(alu_result);
        end else if (bus_wr_done && hit_status) begin
            zero_next = hwdata_i[STAT_ZERO_POS];
        end
    end

    // program counter: jump target, skip over one, or step
    always_comb begin
        pc_next = pc_reg;
        if (exec_now) begin
            if (alu_jump) begin
                pc_next = jump_target;
            end else if (alu_skip) begin
                pc_next = pc_reg + PC_SKIP_STEP;
            end else begin
                pc_next = pc_reg + PC_STEP;
            end
        end else if (bus_wr_done && hit_pc) begin
            pc_next = hwdata_i[PC_W-1:0];
        end
    end

    // execution state flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            acc_reg <= ACC_RST;
            zero_reg <= ZERO_RST;
            pc_reg <= PC_RST;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            pc_reg <= pc_next;
        end
    end

    // instruction and latch registers written from the bus
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            instr_reg <= INSTR_RST;
            pc_latch_reg <= PC_LATCH_RST;
        end else if (bus_wr_done) begin
            if (hit_instr) begin
                instr_reg <= hwdata_i[15:0];
            end
            if (hit_pc_latch) begin
                pc_latch_reg <= hwdata_i[PC_LATCH_W-1:0];
            end
        end
    end

    // instruction cycles spent, second cycles included
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cycles_reg <= CYCLES_RST;
        end else if (busy) begin
            cycles_reg <= cycles_reg + 32'h0000_0001;
        end else if (bus_wr_done && hit_cycles) begin
            cycles_reg <= CYCLES_RST;
        end
    end

endmodule
`default_nettype wire

/* skip_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module skip_core_asserts
    import skip_core_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] hrdata_o
);
    logic taken;
    logic pend_reg;
    logic rd_pend_reg;
    // transfer accepted at this edge
    assign taken = hsel_i && hready_i && htrans_i[1];
    // open data phase, and whether it is a read
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_reg <= 1'h0;
            rd_pend_reg <= 1'h0;
        end else if (taken) begin
            pend_reg <= 1'h1;
            rd_pend_reg <= !hwrite_i;
        end else if (hreadyout_o) begin
            pend_reg <= 1'h0;
            rd_pend_reg <= 1'h0;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    resp_okay_a: assert property (hresp_o == 1'h0)
        else $error("bus response not okay");
    read_wait_a: assert property (taken && !hwrite_i |=> !hreadyout_o)
        else $error("read answered without wait state");
    read_answer_a: assert property (taken && !hwrite_i |=> ##[1:4] hreadyout_o)
        else $error("read never answered");
    write_answer_a: assert property (taken && hwrite_i |=> ##[0:2] hreadyout_o)
        else $error("write stalled too long");
    stall_bound_a: assert property (!hreadyout_o |-> ##[1:4] hreadyout_o)
        else $error("stall longer than allowed");
    stall_cause_a: assert property (!hreadyout_o |-> pend_reg)
        else $error("stall with no data phase open");
    idle_ready_a: assert property (hreadyout_o && !taken |=> hreadyout_o)
        else $error("ready dropped while bus idle");
    rdata_hold_a: assert property (!rd_pend_reg |=> $stable(hrdata_o))
        else $error("read data changed outside a read");
    reset_ready_a: assert property ($rose(rstn_i) |-> hreadyout_o)
        else $error("not ready after reset");
endmodule
bind skip_core skip_core_asserts #(.FILE_DEPTH(FILE_DEPTH)) i_skip_core_asserts (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o)
);
`default_nettype wire

/* bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic sys_clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // bus idle from time zero
    initial begin
        hsel_o = 1'h0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'h0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    // single word transfer, called just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o <= 1'h1;
        htrans_o <= 2'h2;
        haddr_o <= {20'h0, a};
        hwrite_o <= wr;
        do @(posedge sys_clk_i); while (hready_i !== 1'h1);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge sys_clk_i); while (hready_i !== 1'h1);
        q = hrdata_i;
        hwdata_o <= ~d; // released data no longer shows the value
    endtask
endmodule
`default_nettype wire

/* cpu_inc_dec_skip_branch_or_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_inc_dec_skip_branch_or_test
    import skip_core_pkg::*;
;
    typedef struct packed {
        logic [15:0] instr;
        logic [7:0] acc0;
        logic [7:0] f0;
        logic z0;
        logic [6:0] latch;
        logic [7:0] acc1;
        logic [7:0] f1;
        logic z1;
        logic [14:0] pc1;
        logic [7:0] cyc1;
    } row_t;
    logic sys_clk_i, rstn_i, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int miscompares = 0;
    int total_checks = 0;
    row_t r;
    // instruction, presets, then expected acc, file, zero, pc, busy cycles
    row_t rows[13] = '{
        '{16'h1005, 8'h33, 8'h01, 1'h0, 7'h00, 8'h00, 8'h01, 1'h0, 15'h0002, 8'h02},
        '{16'h10FF, 8'h33, 8'h00, 1'h1, 7'h00, 8'h33, 8'hFF, 1'h1, 15'h0001, 8'h01},
        '{16'h2090, 8'h44, 8'hFF, 1'h0, 7'h00, 8'h44, 8'h00, 1'h0, 15'h0002, 8'h02},
        '{16'h2010, 8'h00, 8'h41, 1'h1, 7'h7F, 8'h42, 8'h41, 1'h1, 15'h0001, 8'h01},
        '{16'h307F, 8'h55, 8'hFF, 1'h0, 7'h00, 8'h00, 8'hFF, 1'h1, 15'h0001, 8'h01},
        '{16'h3081, 8'h00, 8'h0F, 1'h1, 7'h00, 8'h00, 8'h10, 1'h0, 15'h0001, 8'h01},
        '{16'h45A5, 8'h66, 8'h12, 1'h1, 7'h47, 8'h66, 8'h12, 1'h1, 15'h45A5, 8'h02},
        '{16'h47FF, 8'h77, 8'h21, 1'h0, 7'h38, 8'h77, 8'h21, 1'h0, 15'h3FFF, 8'h02},
        '{16'h5000, 8'h00, 8'h09, 1'h0, 7'h00, 8'h00, 8'h09, 1'h1, 15'h0001, 8'h01},
        '{16'h50A0, 8'h05, 8'h0C, 1'h1, 7'h00, 8'hA5, 8'h0C, 1'h0, 15'h0001, 8'h01},
        '{16'h6020, 8'h30, 8'h0C, 1'h1, 7'h00, 8'h3C, 8'h0C, 1'h0, 15'h0001, 8'h01},
        '{16'h60A0, 8'h00, 8'h00, 1'h0, 7'h00, 8'h00, 8'h00, 1'h1, 15'h0001, 8'h01},
        '{16'h7003, 8'h11, 8'hAA, 1'h1, 7'h00, 8'h11, 8'hAA, 1'h1, 15'h0001, 8'h01}
    };
    logic [11:0] rst_addrs[7] = '{OFF_INSTR, OFF_ACC, OFF_STATUS, OFF_PC, OFF_PC_LATCH,
                                  OFF_CYCLES, OFF_FILE_LAST};
    skip_core i_skip_core (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata)
    );
    bus_master_model i_bus_master_model (
        .sys_clk_i(sys_clk_i), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata)
    );
    // byte address of a file register
    function automatic logic [11:0] faddr(input logic [6:0] f);
        faddr = OFF_FILE_BASE + {3'h0, f, 2'h0};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_bus_master_model.xfer(1'h1, a, d, q);
    endtask
    // read one word and compare
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_bus_master_model.xfer(1'h0, a, 32'h0, q);
        total_checks++;
        if (q !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, q);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'h0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // watchdog, far beyond the expected run
    initial begin
        #80000;
        miscompares++;
        test_done();
    end
    initial begin
        rstn_i = 1'h0;
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'h1;
        @(posedge sys_clk_i);
        for (int i = 0; i < 7; i++) begin
            rchk("reset value", rst_addrs[i], 32'h0);
        end
        // one instruction per row from preset state
        for (int i = 0; i < 13; i++) begin
            r = rows[i];
            wr(OFF_PC_LATCH, {25'h0, r.latch});
            wr(OFF_ACC, {24'hFFFFFF, r.acc0});
            wr(OFF_STATUS, {31'h0, r.z0});
            wr(OFF_PC, 32'h0);
            wr(faddr(r.instr[6:0]), {24'h0, r.f0});
            wr(OFF_CYCLES, 32'h0);
            wr(OFF_INSTR, {16'h0, r.instr});
            rchk("acc", OFF_ACC, {24'h0, r.acc1});
            rchk("file", faddr(r.instr[6:0]), {24'h0, r.f1});
            rchk("zero", OFF_STATUS, {31'h0, r.z1});
            rchk("pc", OFF_PC, {17'h0, r.pc1});
            rchk("cycles", OFF_CYCLES, {24'h0, r.cyc1});
        end
        // two decrements back to back, the second hits zero
        wr(OFF_PC, 32'h0);
        wr(OFF_CYCLES, 32'h0);
        wr(faddr(7'h05), 32'h02);
        wr(OFF_INSTR, 32'h1085);
        wr(OFF_INSTR, 32'h1085);
        rchk("file", faddr(7'h05), 32'h0);
        rchk("pc", OFF_PC, 32'h3);
        rchk("cycles", OFF_CYCLES, 32'h3);
        // unmapped place and narrow latch
        wr(12'h018, 32'h5A);
        rchk("unmapped", 12'h018, 32'h0);
        wr(OFF_PC_LATCH, 32'hFF);
        rchk("latch", OFF_PC_LATCH, 32'h7F);
        // reset in mid-run clears state
        wr(OFF_ACC, 32'hC3);
        rstn_i <= 1'h0;
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'h1;
        @(posedge sys_clk_i);
        rchk("acc after reset", OFF_ACC, 32'h0);
        rchk("latch after reset", OFF_PC_LATCH, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
